// [uvt_pkg.sv]
/*
 * constants, types and register map of the vbus srp timer with the
 * in-endpoint fifo-empty interrupt gating.
 * assumes one clock (pclk, which also serves as the usb clock) and apb access.
 */
//==============================================================
// What this block does
// - discharge phase always follows the pulse phase
// - discharge lasts 1024 times discharge count cycles
// - pulse lasts 1024 times 12-bit pulse count
// - discharge count resets to 17d7
// - pulse count resets to 05b8
// - fifo-empty flag raises endpoint bit only when enabled
// - enable bit n serves in endpoint n
// - one enables, zero blocks, enables reset zero
// - endpoint interrupt sets its bit in 3:0
package uvt_pkg;

    //==========================================================
    // clock and timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned PRESCALE_DIV = 1024;
    localparam logic [9:0] PRESCALE_LAST = 10'(PRESCALE_DIV - 1);
    localparam int unsigned EP_MAX = 4;

    //==========================================================
    // register offsets (byte addresses)
    localparam logic [11:0] OFS_ALL_EP_IRQ = 12'h818;
    localparam logic [11:0] OFS_DISCHARGE = 12'h828;
    localparam logic [11:0] OFS_PULSE = 12'h82c;
    localparam logic [11:0] OFS_FE_IRQ_EN = 12'h834;
    localparam logic [11:0] OFS_SRP_CTRL = 12'h840;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h844;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h848;

    //==========================================================
    // field positions and reset values
    localparam int unsigned DISCHARGE_W = 16;
    localparam int unsigned PULSE_W = 12;
    localparam logic [15:0] DISCHARGE_RESET = 16'h17d7;
    localparam logic [11:0] PULSE_RESET = 12'h5b8;
    localparam logic [3:0] FE_IRQ_EN_RESET = 4'h0;
    localparam int unsigned CTRL_START_BIT = 0;
    localparam int unsigned IRQ_SRP_DONE_BIT = 0;
    localparam int unsigned IRQ_EP_BIT = 1;
    localparam int unsigned IRQ_W = 2;

    //==========================================================
    // types
    typedef enum logic [2:0] {
        UVT_IDLE = 3'b001,
        UVT_PULSE = 3'b010,
        UVT_DISCHARGE = 3'b100
    } uvt_phase_t;

    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } uvt_apb_req_t;

    typedef struct packed {
        logic [DISCHARGE_W-1:0] discharge_count;
        logic [PULSE_W-1:0] pulse_count;
        logic [EP_MAX-1:0] fe_irq_en;
        logic [EP_MAX-1:0] ep_bits;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        uvt_phase_t phase;
        logic [9:0] prescale;
        logic [15:0] units_left;
        logic [31:0] rdata;
        logic slverr;
    } uvt_state_t;

endpackage

// [uvt_srp_timer.sv]
/*
 * vbus srp pulse/discharge timer, in-endpoint fifo-empty interrupt gating,
 * sticky interrupt status with mask, apb4 slave answering without wait states.
 * assumes pclk is the usb clock and all inputs are synchronous to it.
 */
`timescale 1ns/10ps
`default_nettype none

module uvt_srp_timer
    import uvt_pkg::*;
#(
    parameter int unsigned EP_NUM = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire uvt_apb_req_t apb_req,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [EP_MAX-1:0] tx_fifo_empty_flag,
    input wire logic [EP_MAX-1:0] in_endpoint_irq_flags,
    output logic vbus_pulse_drive,
    output logic vbus_discharge_drive,
    output logic srp_busy,
    output logic [EP_MAX-1:0] in_endpoint_irq_bits,
    output logic irq
);

    //==========================================================
    // elaboration check
    generate
        if (EP_NUM < 1 || EP_NUM > EP_MAX) begin : g_bad_ep_num
            $error("uvt_srp_timer: EP_NUM must lie between 1 and 4");
        end
    endgenerate

    //==========================================================
    // address decode
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_ALL_EP,
        SEL_DIS,
        SEL_PLS,
        SEL_FE_EN,
        SEL_CTRL,
        SEL_STAT,
        SEL_MASK
    } uvt_sel_t;

    function automatic uvt_sel_t decode(input logic [11:0] addr);
        unique case (addr)
            OFS_ALL_EP_IRQ: decode = SEL_ALL_EP;
            OFS_DISCHARGE: decode = SEL_DIS;
            OFS_PULSE: decode = SEL_PLS;
            OFS_FE_IRQ_EN: decode = SEL_FE_EN;
            OFS_SRP_CTRL: decode = SEL_CTRL;
            OFS_IRQ_STATUS: decode = SEL_STAT;
            OFS_IRQ_MASK: decode = SEL_MASK;
            default: decode = SEL_NONE;
        endcase
    endfunction

    //==========================================================
    // endpoint mask: only implemented endpoints take part
    logic [EP_MAX-1:0] ep_present;

    generate
        for (genvar i = 0; i < EP_MAX; i++) begin : g_ep
            assign ep_present[i] = (i < EP_NUM);
        end
    endgenerate

    //==========================================================
    // state
    uvt_state_t r;
    uvt_state_t next_r;

    uvt_sel_t sel;
    logic setup_phase;
    logic access_phase;
    logic wr_ok;
    logic start_req;
    logic tick;
    logic phase_end;
    logic srp_done;
    logic ep_new;
    logic [IRQ_W-1:0] irq_events;
    logic [IRQ_W-1:0] irq_clear;
    logic [31:0] rd_value;

    assign sel = decode(apb_req.paddr);
    assign setup_phase = apb_req.psel && !apb_req.penable;
    assign access_phase = apb_req.psel && apb_req.penable;
    // partial-word writes are refused
    assign wr_ok = access_phase && apb_req.pwrite && (sel != SEL_NONE)
        && (apb_req.pstrb == 4'hf);
    assign start_req = wr_ok && (sel == SEL_CTRL) && apb_req.pwdata[CTRL_START_BIT];
    assign tick = (r.prescale == PRESCALE_LAST);
    // a zero count ends the phase at once; otherwise after count ticks
    assign phase_end = (r.units_left == 16'h0)
        || (tick && r.units_left == 16'h1);
    assign srp_done = (r.phase == UVT_DISCHARGE) && phase_end;

    //==========================================================
    // read mux, captured in the setup cycle
    always_comb begin
        rd_value = 32'h0;
        unique case (sel)
            SEL_ALL_EP: rd_value[EP_MAX-1:0] = r.ep_bits;
            SEL_DIS: rd_value[DISCHARGE_W-1:0] = r.discharge_count;
            SEL_PLS: rd_value[PULSE_W-1:0] = r.pulse_count;
            SEL_FE_EN: rd_value[EP_MAX-1:0] = r.fe_irq_en;
            SEL_CTRL: rd_value[3:0] = {r.phase, srp_busy};
            SEL_STAT: rd_value[IRQ_W-1:0] = r.irq_status;
            SEL_MASK: rd_value[IRQ_W-1:0] = r.irq_mask;
            SEL_NONE: rd_value = 32'h0;
        endcase
    end

    //==========================================================
    // next state
    always_comb begin
        next_r = r;
        irq_events = '0;
        irq_clear = '0;

        // fifo-empty flag passes only where its enable is one
        next_r.ep_bits = ((tx_fifo_empty_flag & r.fe_irq_en)
            | in_endpoint_irq_flags) & ep_present;
        ep_new = |(next_r.ep_bits & ~r.ep_bits);

        // apb slave
        if (setup_phase) begin
            next_r.rdata = rd_value;
            next_r.slverr = (sel == SEL_NONE)
                || (apb_req.pwrite && apb_req.pstrb != 4'hf);
        end
        if (wr_ok) begin
            unique case (sel)
                SEL_DIS: next_r.discharge_count = apb_req.pwdata[DISCHARGE_W-1:0];
                SEL_PLS: next_r.pulse_count = apb_req.pwdata[PULSE_W-1:0];
                SEL_FE_EN: next_r.fe_irq_en = apb_req.pwdata[EP_MAX-1:0] & ep_present;
                SEL_STAT: irq_clear = apb_req.pwdata[IRQ_W-1:0];
                SEL_MASK: next_r.irq_mask = apb_req.pwdata[IRQ_W-1:0];
                default: irq_clear = '0;
            endcase
        end

        // srp sequencer
        unique case (r.phase)
            UVT_IDLE: begin
                if (start_req) begin
                    next_r.phase = UVT_PULSE;
                    next_r.prescale = 10'h0;
                    next_r.units_left = {4'h0, r.pulse_count};
                end
            end
            UVT_PULSE: begin
                next_r.prescale = r.prescale + 10'h1;
                if (phase_end) begin
                    next_r.phase = UVT_DISCHARGE;
                    next_r.prescale = 10'h0;
                    next_r.units_left = r.discharge_count;
                end else if (tick) begin
                    next_r.units_left = r.units_left - 16'h1;
                end
            end
            UVT_DISCHARGE: begin
                next_r.prescale = r.prescale + 10'h1;
                if (phase_end) begin
                    next_r.phase = UVT_IDLE;
                    next_r.prescale = 10'h0;
                    next_r.units_left = 16'h0;
                end else if (tick) begin
                    next_r.units_left = r.units_left - 16'h1;
                end
            end
            default: begin
                next_r.phase = UVT_IDLE;
                next_r.prescale = 10'h0;
                next_r.units_left = 16'h0;
            end
        endcase

        // sticky status; a new event beats a clear in the same cycle
        irq_events[IRQ_SRP_DONE_BIT] = srp_done;
        irq_events[IRQ_EP_BIT] = ep_new;
        next_r.irq_status = (r.irq_status & ~irq_clear) | irq_events;
    end

    //==========================================================
    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r.discharge_count <= DISCHARGE_RESET;
            r.pulse_count <= PULSE_RESET;
            r.fe_irq_en <= FE_IRQ_EN_RESET;
            r.ep_bits <= '0;
            r.irq_status <= '0;
            r.irq_mask <= '0;
            r.phase <= UVT_IDLE;
            r.prescale <= 10'h0;
            r.units_left <= 16'h0;
            r.rdata <= 32'h0;
            r.slverr <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    //==========================================================
    // outputs
    assign pready = access_phase;
    assign prdata = r.rdata;
    assign pslverr = access_phase && r.slverr;
    assign vbus_pulse_drive = (r.phase == UVT_PULSE);
    assign vbus_discharge_drive = (r.phase == UVT_DISCHARGE);
    assign srp_busy = (r.phase != UVT_IDLE);
    assign in_endpoint_irq_bits = r.ep_bits;
    assign irq = |(r.irq_status & r.irq_mask);

endmodule // uvt_srp_timer

`default_nettype wire

// [uvt_srp_timer_asserts.sv]
/* port checker of the srp timer and endpoint interrupt gating.
   assumes it is bound to uvt_srp_timer and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module uvt_srp_timer_asserts
    import uvt_pkg::*;
#(
    parameter int unsigned EP_NUM = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire uvt_apb_req_t apb_req,
    input wire logic pslverr,
    input wire logic [EP_MAX-1:0] tx_fifo_empty_flag,
    input wire logic [EP_MAX-1:0] in_endpoint_irq_flags,
    input wire logic vbus_pulse_drive,
    input wire logic vbus_discharge_drive,
    input wire logic srp_busy,
    input wire logic [EP_MAX-1:0] in_endpoint_irq_bits
);
    //==========================================================
    // shadow of enables, phase run length
    logic [3:0] en;
    logic [1:0] ph;
    logic [31:0] run;
    logic wr_ok;
    assign wr_ok = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.pstrb == 4'hf;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en <= 4'h0;
            ph <= 2'b00;
            run <= 32'h0;
        end else begin
            if (wr_ok && apb_req.paddr == OFS_FE_IRQ_EN) begin
                en <= apb_req.pwdata[3:0];
            end
            ph <= {vbus_pulse_drive, vbus_discharge_drive};
            run <= ({vbus_pulse_drive, vbus_discharge_drive} != ph) ? 32'h1 : run + 32'h1;
        end
    end
    //==========================================================
    // properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_pulse_end; $fell(vbus_pulse_drive); endsequence
    sequence s_disch_start; $rose(vbus_discharge_drive); endsequence
    sequence s_disch_end; $fell(vbus_discharge_drive); endsequence
    property p_disch_follows; s_pulse_end |-> s_disch_start; endproperty
    property p_no_overlap; !(vbus_pulse_drive && vbus_discharge_drive); endproperty
    property p_busy; srp_busy == (vbus_pulse_drive || vbus_discharge_drive); endproperty
    property p_idle_after; s_disch_end |-> !srp_busy; endproperty
    property p_pulse_len; s_pulse_end |-> (run[9:0] == 10'h000 || run == 32'h1); endproperty
    property p_disch_len; s_disch_end |-> (run[9:0] == 10'h000 || run == 32'h1); endproperty
    property p_ep_bits;
        in_endpoint_irq_bits == $past((tx_fifo_empty_flag & en | in_endpoint_irq_flags)
            & 4'((1 << EP_NUM) - 1));
    endproperty
    property p_strb_err;
        apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.pstrb != 4'hf |-> pslverr;
    endproperty
    a_disch_follows: assert property (p_disch_follows)
        else $error("discharge did not follow pulse");
    a_no_overlap: assert property (p_no_overlap)
        else $error("pulse and discharge together");
    a_busy: assert property (p_busy)
        else $error("busy does not match phases");
    a_idle_after: assert property (p_idle_after)
        else $error("busy after discharge");
    a_pulse_len: assert property (p_pulse_len)
        else $error("pulse length not a 1024 multiple");
    a_disch_len: assert property (p_disch_len)
        else $error("discharge length not a 1024 multiple");
    a_ep_bits: assert property (p_ep_bits)
        else $error("endpoint bits wrong");
    a_strb_err: assert property (p_strb_err)
        else $error("partial write not refused");
endmodule // uvt_srp_timer_asserts
bind uvt_srp_timer uvt_srp_timer_asserts #(.EP_NUM(EP_NUM)) u_chk (.pclk(pclk),
    .presetn(presetn), .apb_req(apb_req), .pslverr(pslverr),
    .tx_fifo_empty_flag(tx_fifo_empty_flag), .in_endpoint_irq_flags(in_endpoint_irq_flags),
    .vbus_pulse_drive(vbus_pulse_drive), .vbus_discharge_drive(vbus_discharge_drive),
    .srp_busy(srp_busy), .in_endpoint_irq_bits(in_endpoint_irq_bits));
`default_nettype wire

// [uvt_usb_peer.sv]
/* bus peer that times the vbus pulse and discharge phases.
   assumes the drive outputs are synchronous to pclk. */
`timescale 1ns/10ps
`default_nettype none
module uvt_usb_peer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic vbus_pulse_drive,
    input wire logic vbus_discharge_drive,
    output logic [31:0] pulse_len,
    output logic [31:0] disch_len
);
    //==========================================================
    // phase lengths in cycles
    logic pulse_q;
    logic disch_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_len <= 32'h0;
            disch_len <= 32'h0;
            pulse_q <= 1'b0;
            disch_q <= 1'b0;
        end else begin
            pulse_q <= vbus_pulse_drive;
            disch_q <= vbus_discharge_drive;
            if (vbus_pulse_drive && !pulse_q) pulse_len <= 32'h1;
            else if (vbus_pulse_drive) pulse_len <= pulse_len + 32'h1;
            if (vbus_discharge_drive && !disch_q) disch_len <= 32'h1;
            else if (vbus_discharge_drive) disch_len <= disch_len + 32'h1;
        end
    end
endmodule // uvt_usb_peer
`default_nettype wire

// [test_uvt_srp_timer.sv]
/* self-checking bench of the srp timer over apb.
   assumes uvt_pkg, the peer model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module test_uvt_srp_timer
    import uvt_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    uvt_apb_req_t req = '0;
    logic [3:0] flag = 4'h0;
    logic [3:0] other = 4'h0;
    logic pready, pslverr, pulse, disch, busy, irq, err;
    logic [31:0] prdata, rdv, plen, dlen;
    logic [3:0] bits;
    int fail_count = 0;
    int checked = 0;
    logic [3:0] ep [4][4] = '{'{4'h4, 4'hf, 4'h0, 4'h4}, '{4'h0, 4'hf, 4'h0, 4'h0},
        '{4'h9, 4'h9, 4'h2, 4'hb}, '{4'hf, 4'h0, 4'h0, 4'h0}};
    uvt_srp_timer uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .tx_fifo_empty_flag(flag),
        .in_endpoint_irq_flags(other), .vbus_pulse_drive(pulse),
        .vbus_discharge_drive(disch), .srp_busy(busy), .in_endpoint_irq_bits(bits), .irq(irq));
    uvt_usb_peer peer (.pclk(pclk), .presetn(presetn), .vbus_pulse_drive(pulse),
        .vbus_discharge_drive(disch), .pulse_len(plen), .disch_len(dlen));
    initial begin
        forever #50 pclk = ~pclk;
    end
    //==========================================================
    // bus and compare tasks
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        req.pstrb <= s;
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0, 4'hf);
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic print_verdict;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        print_verdict;
    end
    //==========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_FE_IRQ_EN, {28'h0, ep[i][0]});
            flag <= ep[i][1];
            other <= ep[i][2];
            repeat (2) @(posedge pclk);
            chk("ep_bits", {28'h0, ep[i][3]}, {28'h0, bits});
            rd(OFS_ALL_EP_IRQ);
            chk("all_ep_reg", {28'h0, ep[i][3]}, rdv);
        end
        apb(1'b1, 12'h900, 32'h1, 4'hf);
        chk("unmapped_err", 32'h1, 32'(err));
        apb(1'b1, OFS_PULSE, 32'h7, 4'h3);
        chk("strb_err", 32'h1, 32'(err));
        rd(OFS_PULSE);
        chk("strb_no_effect", 32'h5b8, rdv);
        wr(OFS_IRQ_MASK, 32'h1);
        wr(OFS_IRQ_STATUS, 32'h3);
        wr(OFS_PULSE, 32'h1);
        wr(OFS_DISCHARGE, 32'h2);
        wr(OFS_SRP_CTRL, 32'h1);
        rd(OFS_SRP_CTRL);
        chk("ctrl_pulse", 32'h5, rdv);
        wr(OFS_SRP_CTRL, 32'h1);
        while (busy !== 1'b0) begin
            @(posedge pclk);
        end
        chk("pulse_len", 32'd1024, plen);
        chk("disch_len", 32'd2048, dlen);
        chk("done_irq", 32'h1, 32'(irq));
        rd(OFS_IRQ_STATUS);
        chk("status_sticky", 32'h1, rdv);
        wr(OFS_IRQ_STATUS, 32'h1);
        chk("irq_clear", 32'h0, 32'(irq));
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(OFS_DISCHARGE);
        chk("disch_reset", 32'h17d7, rdv);
        rd(OFS_PULSE);
        chk("pulse_reset", 32'h5b8, rdv);
        rd(OFS_FE_IRQ_EN);
        chk("en_reset", 32'h0, rdv);
        print_verdict;
    end
endmodule // test_uvt_srp_timer
`default_nettype wire
